/* shared/ipc_pkg.sv */
/*
  Shared constants for the I/O pin configuration and DAC write block:
  pointer-byte modes, register selectors, field positions, reset values,
  load-mode encodings and the serial receiver state type.
  Assumes it is compiled before any design file that names it.
*/
`default_nettype none

package ipc_pkg;

  // pointer byte upper nibble
  localparam logic [3:0] MODE_CTRL    = 4'h0;
  localparam logic [3:0] MODE_DAC     = 4'h1;

  // control register selectors, pointer low nibble
  localparam logic [3:0] REG_GP       = 4'h3;
  localparam logic [3:0] REG_ADC_CFG  = 4'h4;
  localparam logic [3:0] REG_DAC_CFG  = 4'h5;
  localparam logic [3:0] REG_PD_CFG   = 4'h6;
  localparam logic [3:0] REG_LD_MODE  = 4'h7;
  localparam logic [3:0] REG_GPO_CFG  = 4'h8;
  localparam logic [3:0] REG_GPO_DATA = 4'h9;
  localparam logic [3:0] REG_GPI_CFG  = 4'hA;
  localparam logic [3:0] REG_OD_CFG   = 4'hC;
  localparam logic [3:0] REG_TRI_CFG  = 4'hD;

  // misc_analog_control field positions
  localparam int unsigned GP_PRECHARGE_BIT = 9;
  localparam int unsigned GP_BUF_EN_BIT    = 8;
  localparam int unsigned GP_LOCK_BIT      = 7;
  localparam int unsigned GP_WR_ALL_BIT    = 6;
  localparam int unsigned GP_ADC_RANGE_BIT = 5;
  localparam int unsigned GP_DAC_RANGE_BIT = 4;
  localparam logic [15:0] GP_DEFINED_MASK  = 16'h03F0;

  // values after reset
  localparam logic [15:0] GP_RST      = 16'h0000;
  localparam logic [7:0]  CFG_RST     = 8'h00;
  localparam logic [7:0]  PD_CFG_RST  = 8'hFF;
  localparam logic [11:0] DAC_RST     = 12'h000;

  // dac_load_mode encodings
  localparam logic [1:0] LOAD_DIRECT  = 2'h0;
  localparam logic [1:0] LOAD_HOLD    = 2'h1;
  localparam logic [1:0] LOAD_XFER    = 2'h2;

  localparam int unsigned NUM_CH = 8;
  localparam int unsigned DAC_W  = 12;

  // byte position inside a write frame
  localparam logic [1:0] BYTE_ADDR = 2'h0;
  localparam logic [1:0] BYTE_PTR  = 2'h1;
  localparam logic [1:0] BYTE_MSB  = 2'h2;
  localparam logic [1:0] BYTE_LSB  = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_BITS = 4'h2,
    ST_ACK  = 4'h4,
    ST_SKIP = 4'h8
  } ipc_rx_st_e;

endpackage : ipc_pkg

`default_nettype wire

/* src/ipc_top.sv */
/*
  I/O pin configuration and DAC write logic behind a two-wire serial
  write port: frame receiver, control and pin configuration registers,
  pin function resolution, digital pin drive and DAC input/output codes.
  Assumes scl/sda and pin inputs are asynchronous pins, adc_conv_active
  comes from the ADC sequencer on clk_sys, and an outside pad resolves
  the open-drain sda level from sda_o/sda_oe_n.
*/
`timescale 1ns/10ps
`default_nettype none

module ipc_top #(
  parameter logic [6:0] SLAVE_ADDR = 7'h10  // bus address, arbitrary value
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         scl_i,
  input  wire logic         sda_i,
  output logic              sda_o,
  output logic              sda_oe_n,
  input  wire logic [7:0]   pin_i,
  output logic [7:0]        pin_o,
  output logic [7:0]        pin_oe_n,
  output logic [7:0]        pin_dac_en,
  output logic [7:0]        pin_adc_en,
  output logic [7:0]        pin_pd_en,
  output logic [7:0]        pin_tri_en,
  input  wire logic         adc_conv_active,
  output logic              adc_buf_pwr,
  output logic              adc_range_2x,
  output logic              dac_range_2x,
  output logic [7:0]        gpio_rd_val,
  output logic [95:0]       dac_code
);

  // pin synchronisers; stage 0 is read only by stage 1
  logic [2:0]           scl_sr_q;
  logic [2:0]           sda_sr_q;
  logic [7:0]           pin_s1_q;
  logic [7:0]           pin_s2_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_sr_q <= 3'h7;
      sda_sr_q <= 3'h7;
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
    end else begin
      scl_sr_q <= {scl_sr_q[1:0], scl_i};
      sda_sr_q <= {sda_sr_q[1:0], sda_i};
      pin_s1_q <= pin_i;
      pin_s2_q <= pin_s1_q;
    end
  end

  // bus events from synchronised levels
  wire logic scl_rise   = scl_sr_q[1] & ~scl_sr_q[2];
  wire logic scl_fall   = ~scl_sr_q[1] & scl_sr_q[2];
  wire logic start_cond = scl_sr_q[1] & scl_sr_q[2] & ~sda_sr_q[1] & sda_sr_q[2];
  wire logic stop_cond  = scl_sr_q[1] & scl_sr_q[2] & sda_sr_q[1] & ~sda_sr_q[2];

  ipc_pkg::ipc_rx_st_e  st_q;
  logic [2:0]           bit_cnt_q;
  logic [1:0]           byte_idx_q;
  logic [6:0]           shift_q;
  logic                 ack_q;
  logic [7:0]           ptr_q;
  logic [7:0]           msb_q;
  logic [15:0]          wr_data_q;
  logic                 wr_stb_q;

  wire logic [7:0] rx_byte  = {shift_q, sda_sr_q[1]};
  wire logic       last_bit = (st_q == ipc_pkg::ST_BITS) && scl_rise && (bit_cnt_q == 3'h7);
  wire logic       addr_ok  = (rx_byte[7:1] == SLAVE_ADDR) && !rx_byte[0];
  wire logic [1:0] idx_next = (byte_idx_q == ipc_pkg::BYTE_LSB) ? ipc_pkg::BYTE_MSB : byte_idx_q + 2'h1;

  // frame receiver; reads and foreign addresses are left unacknowledged
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q       <= ipc_pkg::ST_IDLE;
      bit_cnt_q  <= 3'h0;
      byte_idx_q <= ipc_pkg::BYTE_ADDR;
      shift_q    <= 7'h00;
      ack_q      <= 1'b0;
    end else if (start_cond) begin
      st_q       <= ipc_pkg::ST_BITS;
      bit_cnt_q  <= 3'h0;
      byte_idx_q <= ipc_pkg::BYTE_ADDR;
      ack_q      <= 1'b0;
    end else if (stop_cond) begin
      st_q  <= ipc_pkg::ST_IDLE;
      ack_q <= 1'b0;
    end else begin
      case (st_q)
        ipc_pkg::ST_BITS: begin
          if (scl_rise) begin
            shift_q   <= rx_byte[6:0];
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7) begin
              st_q <= (byte_idx_q != ipc_pkg::BYTE_ADDR || addr_ok) ? ipc_pkg::ST_ACK : ipc_pkg::ST_SKIP;
            end
          end
        end
        ipc_pkg::ST_ACK: begin
          // drive low from the falling edge after bit 8 until the one after the ack clock
          if (scl_fall) begin
            ack_q <= !ack_q;
            if (ack_q) begin
              st_q       <= ipc_pkg::ST_BITS;
              byte_idx_q <= idx_next;
            end
          end
        end
        default: begin
          st_q <= st_q;
        end
      endcase
    end
  end

  // byte capture; a pair of data bytes commits as one word
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ptr_q     <= 8'h00;
      msb_q     <= 8'h00;
      wr_data_q <= 16'h0000;
      wr_stb_q  <= 1'b0;
    end else begin
      wr_stb_q <= last_bit && (byte_idx_q == ipc_pkg::BYTE_LSB);
      if (last_bit && byte_idx_q == ipc_pkg::BYTE_PTR) ptr_q <= rx_byte;
      if (last_bit && byte_idx_q == ipc_pkg::BYTE_MSB) msb_q <= rx_byte;
      if (last_bit && byte_idx_q == ipc_pkg::BYTE_LSB) wr_data_q <= {msb_q, rx_byte};
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_n = ~ack_q;

  logic [15:0]          gp_q;
  logic [7:0]           adc_cfg_q;
  logic [7:0]           dac_cfg_q;
  logic [7:0]           pd_cfg_q;
  logic [7:0]           gpo_cfg_q;
  logic [7:0]           gpi_cfg_q;
  logic [7:0]           od_cfg_q;
  logic [7:0]           tri_cfg_q;
  logic [7:0]           gpo_data_q;
  logic [1:0]           dac_load_mode_q;

  // write decode
  wire logic [3:0] sel    = ptr_q[3:0];
  wire logic [7:0] wd     = wr_data_q[7:0];
  wire logic       ctl_wr = wr_stb_q && (ptr_q[7:4] == ipc_pkg::MODE_CTRL);
  wire logic       dac_wr = wr_stb_q && (ptr_q[7:4] == ipc_pkg::MODE_DAC);
  wire logic       lock   = gp_q[ipc_pkg::GP_LOCK_BIT];
  wire logic       cfg_ok = ctl_wr && !lock;
  wire logic       w_adc  = cfg_ok && (sel == ipc_pkg::REG_ADC_CFG);
  wire logic       w_dac  = cfg_ok && (sel == ipc_pkg::REG_DAC_CFG);
  wire logic       w_pd   = cfg_ok && (sel == ipc_pkg::REG_PD_CFG);
  wire logic       w_gpo  = cfg_ok && (sel == ipc_pkg::REG_GPO_CFG);
  wire logic       w_gpi  = cfg_ok && (sel == ipc_pkg::REG_GPI_CFG);
  wire logic       w_od   = cfg_ok && (sel == ipc_pkg::REG_OD_CFG);
  wire logic       w_tri  = cfg_ok && (sel == ipc_pkg::REG_TRI_CFG);
  wire logic       w_gp   = ctl_wr && (sel == ipc_pkg::REG_GP);
  wire logic       w_load = ctl_wr && (sel == ipc_pkg::REG_LD_MODE);
  wire logic       w_gpd  = ctl_wr && (sel == ipc_pkg::REG_GPO_DATA);
  wire logic       xfer   = w_load && (wd[1:0] == ipc_pkg::LOAD_XFER);

  // function classes: analog pair, digital pair, three-state, pull-down
  wire logic hit_an  = w_adc | w_dac;
  wire logic hit_dig = w_gpo | w_gpi;

  // own register takes the data; set bits are cleared from rival classes
  function automatic logic [7:0] cfg_next(input logic [7:0] cur, input logic own,
                                          input logic rival, input logic [7:0] d);
    cfg_next = own ? d : (rival ? (cur & ~d) : cur);
  endfunction : cfg_next

  wire logic [7:0] adc_cfg_d = cfg_next(adc_cfg_q, w_adc, hit_dig | w_tri | w_pd, wd);
  wire logic [7:0] dac_cfg_d = cfg_next(dac_cfg_q, w_dac, hit_dig | w_tri | w_pd, wd);
  wire logic [7:0] gpo_cfg_d = cfg_next(gpo_cfg_q, w_gpo, hit_an | w_tri | w_pd, wd);
  wire logic [7:0] gpi_cfg_d = cfg_next(gpi_cfg_q, w_gpi, hit_an | w_tri | w_pd, wd);
  wire logic [7:0] tri_cfg_d = cfg_next(tri_cfg_q, w_tri, hit_an | hit_dig | w_pd, wd);
  wire logic [7:0] pd_cfg_d  = cfg_next(pd_cfg_q, w_pd, hit_an | hit_dig | w_tri, wd);

  // configuration registers; pull-down owns every pin after reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      adc_cfg_q <= ipc_pkg::CFG_RST;
      dac_cfg_q <= ipc_pkg::CFG_RST;
      gpo_cfg_q <= ipc_pkg::CFG_RST;
      gpi_cfg_q <= ipc_pkg::CFG_RST;
      tri_cfg_q <= ipc_pkg::CFG_RST;
      pd_cfg_q  <= ipc_pkg::PD_CFG_RST;
      od_cfg_q  <= ipc_pkg::CFG_RST;
    end else begin
      adc_cfg_q <= adc_cfg_d;
      dac_cfg_q <= dac_cfg_d;
      gpo_cfg_q <= gpo_cfg_d;
      gpi_cfg_q <= gpi_cfg_d;
      tri_cfg_q <= tri_cfg_d;
      pd_cfg_q  <= pd_cfg_d;
      if (w_od) od_cfg_q <= wd;
    end
  end

  // control, output data and load mode; reserved bits are never stored
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gp_q            <= ipc_pkg::GP_RST;
      gpo_data_q      <= ipc_pkg::CFG_RST;
      dac_load_mode_q <= ipc_pkg::LOAD_DIRECT;
    end else begin
      if (w_gp) gp_q <= wr_data_q & ipc_pkg::GP_DEFINED_MASK;
      if (w_gpd) gpo_data_q <= wd;
      if (xfer) dac_load_mode_q <= ipc_pkg::LOAD_HOLD;
      else if (w_load) dac_load_mode_q <= wd[1:0];
    end
  end

  // per-channel input and output codes
  for (genvar c = 0; c < ipc_pkg::NUM_CH; c++) begin : g_dac
    logic [11:0] in_q;
    logic [11:0] out_q;
    wire logic hit = dac_wr && (gp_q[ipc_pkg::GP_WR_ALL_BIT] ? dac_cfg_q[c] : ptr_q[2:0] == 3'(c));

    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        in_q  <= ipc_pkg::DAC_RST;
        out_q <= ipc_pkg::DAC_RST;
      end else begin
        if (hit) in_q <= wr_data_q[11:0];
        if (xfer) out_q <= in_q;
        else if (hit && dac_load_mode_q == ipc_pkg::LOAD_DIRECT) out_q <= wr_data_q[11:0];
      end
    end

    assign dac_code[c*ipc_pkg::DAC_W +: ipc_pkg::DAC_W] = out_q;
  end

  logic [7:0]           pin_o_q;
  logic [7:0]           pin_oe_n_q;
  logic [7:0]           gpio_rd_q;
  logic                 buf_pwr_q;

  // open-drain only pulls low; a released high is left to the pull-up
  wire logic [7:0] drive  = gpo_cfg_q & (~od_cfg_q | ~gpo_data_q);
  wire logic       buf_on = gp_q[ipc_pkg::GP_BUF_EN_BIT]
                          & (~gp_q[ipc_pkg::GP_PRECHARGE_BIT] | adc_conv_active);

  // registered pin drive, read path and buffer power
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_o_q    <= 8'h00;
      pin_oe_n_q <= 8'hFF;
      gpio_rd_q  <= 8'h00;
      buf_pwr_q  <= 1'b0;
    end else begin
      pin_o_q    <= gpo_data_q & ~od_cfg_q;
      pin_oe_n_q <= ~drive;
      gpio_rd_q  <= (gpo_cfg_q & gpo_data_q) | (~gpo_cfg_q & gpi_cfg_q & pin_s2_q);
      buf_pwr_q  <= buf_on;
    end
  end

  assign pin_o        = pin_o_q;
  assign pin_oe_n     = pin_oe_n_q;
  assign gpio_rd_val  = gpio_rd_q;
  assign adc_buf_pwr  = buf_pwr_q;
  assign pin_dac_en   = dac_cfg_q;
  assign pin_adc_en   = adc_cfg_q;
  assign pin_pd_en    = pd_cfg_q;
  assign pin_tri_en   = tri_cfg_q;
  assign adc_range_2x = gp_q[ipc_pkg::GP_ADC_RANGE_BIT];
  assign dac_range_2x = gp_q[ipc_pkg::GP_DAC_RANGE_BIT];

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_xfer_req;
    w_load && wd[1:0] == ipc_pkg::LOAD_XFER;
  endsequence
  sequence s_xfer_done;
    dac_load_mode_q == ipc_pkg::LOAD_HOLD && g_dac[2].out_q == $past(g_dac[2].in_q);
  endsequence

  lock_blocks_cfg_a: assert property (ctl_wr && lock && sel != ipc_pkg::REG_GP |=>
    $stable(dac_cfg_q) && $stable(adc_cfg_q) && $stable(pd_cfg_q) && $stable(gpo_cfg_q))
    else $error("pin configuration changed while locked");
  gp_always_wr_a: assert property (ctl_wr && sel == ipc_pkg::REG_GP |=>
    lock == $past(wr_data_q[ipc_pkg::GP_LOCK_BIT]) && gp_q[15:10] == 6'h00)
    else $error("control register write not taken");
  dac_wins_pin_a: assert property (w_dac && wd[0] |=> dac_cfg_q[0] && !gpo_cfg_q[0]
    && !pd_cfg_q[0] && !tri_cfg_q[0] && adc_cfg_q[0] == $past(adc_cfg_q[0]))
    else $error("latest configuration write did not win");
  buf_precharge_a: assert property ((gp_q[9:8] == 2'h3 && !adc_conv_active)[*2] |-> !adc_buf_pwr)
    else $error("precharge buffer powered outside conversion");
  buf_enable_a: assert property ($rose(gp_q[ipc_pkg::GP_BUF_EN_BIT]) && !gp_q[9] |=> adc_buf_pwr)
    else $error("enabled buffer not powered");
  write_all_a: assert property (dac_wr && gp_q[6] && dac_cfg_q[7] |=> g_dac[7].in_q == $past(wr_data_q[11:0]))
    else $error("write-all missed a DAC channel");
  load_xfer_a: assert property (s_xfer_req |=> s_xfer_done)
    else $error("load transfer or revert missing");
  hold_mode_a: assert property (dac_wr && dac_load_mode_q == ipc_pkg::LOAD_HOLD && !xfer |=>
    $stable(g_dac[3].out_q))
    else $error("held DAC output changed");
  gpio_echo_a: assert property (gpo_cfg_q[0] |=> gpio_rd_val[0] == $past(gpo_data_q[0]))
    else $error("output pin read path wrong");
  open_drain_a: assert property (gpo_cfg_q[0] && od_cfg_q[0] && gpo_data_q[0] |=> pin_oe_n[0])
    else $error("open-drain pin drove high");

endmodule : ipc_top

`default_nettype wire

/* tb/io_pin_config_and_dac_write_test.sv */
/*
  Self-checking bench for the pin configuration and DAC write block.
  Assumes the bus host model drives the serial port; sda has a pull-up.
*/
`timescale 1ns/10ps
`default_nettype none

module io_pin_config_and_dac_write_test;
  localparam logic [6:0] DEV_ADDR = 7'h2A;  // arbitrary bus address
  logic        clk_sys, rst, scl, sda_low, sda_line, adc_conv_active, slow;
  logic        sda_o, sda_oe_n, adc_buf_pwr, adc_range_2x, dac_range_2x;
  logic [7:0]  pin_i, pin_o, pin_oe_n, pin_dac_en, pin_adc_en;
  logic [7:0]  pin_pd_en, pin_tri_en, gpio_rd_val;
  logic [95:0] dac_code;
  int          errors, checked;

  // wired-and of both open-drain parties, pull-up when released
  assign sda_line = ~(sda_low | ~sda_oe_n);

  ipc_top #(.SLAVE_ADDR(DEV_ADDR)) dut (.clk_sys(clk_sys), .rst(rst), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe_n(pin_oe_n), .pin_dac_en(pin_dac_en),
    .pin_adc_en(pin_adc_en), .pin_pd_en(pin_pd_en), .pin_tri_en(pin_tri_en),
    .adc_conv_active(adc_conv_active), .adc_buf_pwr(adc_buf_pwr),
    .adc_range_2x(adc_range_2x), .dac_range_2x(dac_range_2x),
    .gpio_rd_val(gpio_rd_val), .dac_code(dac_code));

  ipc_bus_host host (.clk(clk_sys), .slow(slow), .sda_line(sda_line),
    .scl(scl), .sda_low(sda_low));

  // sample 1 ns after the edge so registered outputs have landed
  task automatic chk(input string name, input logic [95:0] seen, input logic [95:0] exp);
    #1;
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] ptr, input logic [15:0] data);
    logic [3:0] acks;
    host.frame(DEV_ADDR, ptr, data, acks);
    chk("ack", acks, 4'hF);
  endtask : wr

  task automatic t_reset();
    chk("pd_en", pin_pd_en, 8'hFF);
    chk("fn_en", {pin_dac_en, pin_adc_en, pin_tri_en}, 24'h000000);
    chk("oe_n", pin_oe_n, 8'hFF);
    chk("buf", adc_buf_pwr, 1'b0);
    chk("dac_code", dac_code, 96'h0);
    chk("sda", {sda_o, sda_oe_n}, 2'h1);
  endtask : t_reset

  // precharge gates buffer power by conversion activity
  task automatic t_ctrl();
    wr({ipc_pkg::MODE_CTRL, ipc_pkg::REG_GP}, 16'h0330);
    chk("ranges", {adc_range_2x, dac_range_2x}, 2'h3);
    chk("buf", adc_buf_pwr, 1'b0);
    @(posedge clk_sys);
    adc_conv_active <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("buf", adc_buf_pwr, 1'b1);
    @(posedge clk_sys);
    adc_conv_active <= 1'b0;
    wr({ipc_pkg::MODE_CTRL, ipc_pkg::REG_GP}, 16'h0100);
    chk("buf", adc_buf_pwr, 1'b1);
    chk("ranges", {adc_range_2x, dac_range_2x}, 2'h0);
  endtask : t_ctrl

  // analog writes take pins from pull-down; ADC and DAC may share a pin
  task automatic t_cfg();
    wr({ipc_pkg::MODE_CTRL, ipc_pkg::REG_DAC_CFG}, 16'h0082);
    chk("dac_en", pin_dac_en, 8'h82);
    chk("pd_en", pin_pd_en, 8'h7D);
    wr({ipc_pkg::MODE_CTRL, ipc_pkg::REG_ADC_CFG}, 16'h0002);
    chk("dac_adc", {pin_dac_en, pin_adc_en}, 16'h8202);
    chk("oe_n", pin_oe_n, 8'hFF);
  endtask : t_cfg

  task automatic t_gpio();
    @(posedge clk_sys);
    pin_i <= 8'h02;
    wr({ipc_pkg::MODE_CTRL, ipc_pkg::REG_GPO_CFG}, 16'h0001);
    wr({ipc_pkg::MODE_CTRL, ipc_pkg::REG_GPI_CFG}, 16'h0003);
    wr({ipc_pkg::MODE_CTRL, ipc_pkg::REG_GPO_DATA}, 16'h0001);
    chk("dac_adc", {pin_dac_en, pin_adc_en}, 16'h8000);
    chk("oe_n", pin_oe_n, 8'hFE);
    chk("pin_o0", pin_o[0], 1'b1);
    chk("rd", gpio_rd_val, 8'h03);
    wr({ipc_pkg::MODE_CTRL, ipc_pkg::REG_OD_CFG}, 16'h0001);
    chk("oe_n", pin_oe_n, 8'hFF);
    wr({ipc_pkg::MODE_CTRL, ipc_pkg::REG_GPO_DATA}, 16'h0000);
    chk("oe_n", pin_oe_n, 8'hFE);
    chk("rd", gpio_rd_val, 8'h02);
  endtask : t_gpio

  // lock blocks pin registers but never the control register
  task automatic t_lock();
    wr({ipc_pkg::MODE_CTRL, ipc_pkg::REG_GP}, 16'h0080);
    wr({ipc_pkg::MODE_CTRL, ipc_pkg::REG_DAC_CFG}, 16'h00FF);
    chk("dac_en", pin_dac_en, 8'h80);
    wr({ipc_pkg::MODE_CTRL, ipc_pkg::REG_TRI_CFG}, 16'h0010);
    chk("tri", pin_tri_en, 8'h00);
    wr({ipc_pkg::MODE_CTRL, ipc_pkg::REG_GP}, 16'h0000);
    wr({ipc_pkg::MODE_CTRL, ipc_pkg::REG_TRI_CFG}, 16'h0010);
    chk("tri", pin_tri_en, 8'h10);
  endtask : t_lock

  // every load mode, then write-all; host runs slow here
  task automatic t_dac();
    @(posedge clk_sys);
    slow <= 1'b1;
    @(posedge clk_sys);
    wr({ipc_pkg::MODE_DAC, 4'h7}, 16'h0ABC);
    chk("ch7", dac_code[95:84], 12'hABC);
    wr({ipc_pkg::MODE_CTRL, ipc_pkg::REG_LD_MODE}, 16'h0001);
    wr({ipc_pkg::MODE_DAC, 4'h3}, 16'h0123);
    chk("ch3", dac_code[47:36], 12'h000);
    wr({ipc_pkg::MODE_CTRL, ipc_pkg::REG_LD_MODE}, 16'h0002);
    chk("ch3", dac_code[47:36], 12'h123);
    wr({ipc_pkg::MODE_DAC, 4'h3}, 16'h0456);
    chk("ch3", dac_code[47:36], 12'h123);
    wr({ipc_pkg::MODE_CTRL, ipc_pkg::REG_LD_MODE}, 16'h0000);
    wr({ipc_pkg::MODE_CTRL, ipc_pkg::REG_GP}, 16'h0140);
    chk("buf", adc_buf_pwr, 1'b1);
    wr({ipc_pkg::MODE_DAC, 4'h0}, 16'h0555);
    chk("all", {dac_code[95:84], dac_code[11:0]}, 24'h555000);
    wr({ipc_pkg::MODE_CTRL, ipc_pkg::REG_DAC_CFG}, 16'h0081);
    chk("dac_en", pin_dac_en, 8'h81);
    chk("oe_n", pin_oe_n, 8'hFF);
    wr({ipc_pkg::MODE_DAC, 4'h3}, 16'h0666);
    chk("all", {dac_code[95:84], dac_code[47:36], dac_code[11:0]}, 36'h666123666);
    slow <= 1'b0;
  endtask : t_dac

  // foreign address: no acknowledge, no register change
  task automatic t_refuse();
    logic [3:0] acks;
    host.frame(DEV_ADDR ^ 7'h01, {ipc_pkg::MODE_CTRL, ipc_pkg::REG_GP}, 16'h0030, acks);
    chk("ack", acks, 4'h0);
    chk("ranges", {adc_range_2x, dac_range_2x}, 2'h0);
  endtask : t_refuse

  task automatic final_report();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial begin
    rst             = 1'b1;
    pin_i           = 8'h00;
    adc_conv_active = 1'b0;
    slow            = 1'b0;
    errors          = 0;
    checked         = 0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_ctrl();
    t_cfg();
    t_gpio();
    t_lock();
    t_dac();
    t_refuse();
    final_report();
  end
endmodule : io_pin_config_and_dac_write_test

`default_nettype wire

/* tb/ipc_bus_host.sv */
/*
  Two-wire bus host model: start, address with write bit, pointer byte,
  two data bytes, stop; captures the acknowledge of every byte.
  Assumes the bench resolves the open-drain data line with a pull-up.
*/
`timescale 1ns/10ps
`default_nettype none

module ipc_bus_host (
  input  wire logic clk,
  input  wire logic slow,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  // bus idles released, clock high
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // quarter bit, long against the 3-flop input sync of the device
  task automatic quarter();
    repeat (slow ? 8 : 4) @(posedge clk);
  endtask : quarter

  // data moves only while clock is low, msb first
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low <= ~b[i];
      quarter();
      scl <= 1'b1;
      quarter();
      quarter();
      scl <= 1'b0;
      quarter();
    end
    sda_low <= 1'b0;
    quarter();
    scl <= 1'b1;
    quarter();
    ack = ~sda_line;
    quarter();
    scl <= 1'b0;
    quarter();
  endtask : put_byte

  // whole write frame; a refused byte is still clocked out
  task automatic frame(input logic [6:0] addr, input logic [7:0] ptr,
                       input logic [15:0] data, output logic [3:0] acks);
    logic        a;
    logic [31:0] bytes;
    bytes = {addr, 1'b0, ptr, data};
    sda_low <= 1'b1;
    quarter();
    scl <= 1'b0;
    quarter();
    for (int k = 3; k >= 0; k--) begin
      put_byte(bytes[8*k +: 8], a);
      acks[k] = a;
    end
    sda_low <= 1'b1;
    quarter();
    scl <= 1'b1;
    quarter();
    sda_low <= 1'b0;
    quarter();
    quarter();
  endtask : frame
endmodule : ipc_bus_host

`default_nettype wire
